// *** ccc_pkg.sv ***
// constants, field layout and carrier types of the charger control block
// assumes a write-word front end on clk_sys delivering decoded words
// Behaviour
// [RQ1] control_word_c 10:9 selects overcurrent alert debounce
// [RQ2] low rail alert uses fixed 10us debounce
// [RQ3] control_word_c 8:6 sets minimum alert hold
// [RQ4] command 0x39 writes control_word_a, 8 bits
// [RQ5] commands 0x3c, 0x3d write words b, c
// [RQ6] no ceiling write for 175s halts charging
// [RQ7] ceiling write after timeout resumes charging
// [RQ8] control_word_a bit 7 high disables watchdog
// [RQ9] bits 6:5 select high-side short threshold
// [RQ10] bits 4:3 select low-power discharge threshold
// [RQ11] low-power discharge compare only with power monitor
// [RQ12] bit 2 high disables input voltage loop
// [RQ13] bits 1:0 select input regulation reference
// [RQ14] overcurrent asserts alert after debounce, holds minimum
// [RQ15] discharge alert needs monitor unless adapter present
// [RQ16] control_word_b bit 3 enables power monitor
// [RQ17] watchdog restarts on ceiling write, pauses without adapter or when disabled
package ccc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS = 1000;
  localparam int TICK_US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;
  localparam int MS_PER_S = 1000;
  localparam int TIMEOUT_S = 175;
  localparam int WD_W = 18;
  localparam int CNT_W = 14;

  localparam logic [7:0] CMD_CTRL_A = 8'h39;
  localparam logic [7:0] CMD_CTRL_B = 8'h3c;
  localparam logic [7:0] CMD_CTRL_C = 8'h3d;
  localparam logic [7:0] CMD_CHG_CUR = 8'h14;
  localparam logic [7:0] CMD_CHG_VOLT = 8'h15;

  localparam logic [15:0] RST_CTRL_A = 16'h0000;
  localparam logic [15:0] RST_CTRL_B = 16'h0000;
  localparam logic [15:0] RST_CTRL_C = 16'h0000;
  localparam int A_USED_W = 8;
  localparam int A_WDOG_DIS = 7;
  localparam int A_HS_SHORT_LSB = 5;
  localparam int A_DCHG_LP_LSB = 3;
  localparam int A_VIN_DIS = 2;
  localparam int A_VIN_REF_LSB = 0;
  localparam int B_SYSTEM_POWER_MONITOR_EN = 3;
  localparam int C_DBC_LSB = 9;
  localparam int C_HOLD_LSB = 6;

  localparam logic [CNT_W-1:0] LOW_RAIL_DBC_US = 14'h000a;
  localparam logic [3:0][CNT_W-1:0] DBC_US_TABLE =
    {14'h03e8, 14'h01f4, 14'h0064, 14'h0007};
  localparam logic [7:0][CNT_W-1:0] HOLD_US_TABLE =
    {14'h2710, 14'h1d4c, 14'h1388, 14'h0fa0,
     14'h0bb8, 14'h07d0, 14'h03e8, 14'h01f4};

  localparam int NIN = 5;
  localparam int IN_AC = 0;
  localparam int IN_DC = 1;
  localparam int IN_LR = 2;
  localparam int IN_ADP = 3;
  localparam int IN_LP = 4;
  localparam int NSRC = 3;

  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [15:0] data;
  } ccc_wr_t;

  typedef struct packed {
    logic [1:0] hs_short_sel;
    logic [1:0] dchg_lp_sel;
    logic dchg_lp_active;
    logic vin_loop_dis;
    logic [1:0] vin_ref_sel;
    logic system_power_monitor_en;
    logic cmp_ref_active;
  } ccc_cfg_t;

  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] s3;
    logic [NIN-1:0] filt;
    logic [15:0] ctrl_a;
    logic [15:0] ctrl_b;
    logic [15:0] ctrl_c;
    logic [7:0] us_div;
    logic [9:0] ms_div;
    logic [WD_W-1:0] wd_cnt;
    logic timed_out;
    logic [NSRC-1:0][CNT_W-1:0] dbc_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic alert;
  } ccc_state_t;
endpackage : ccc_pkg

// *** ccc_charger_ctrl.sv ***
// control registers, bus watchdog and throttle alert timing
// assumes write words arrive as one-cycle pulses on clk_sys;
// comparator and presence pins are asynchronous
`timescale 1ns/1ps
module ccc_charger_ctrl #(
  parameter int TIMEOUT_MS = ccc_pkg::TIMEOUT_S * ccc_pkg::MS_PER_S
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire ccc_pkg::ccc_wr_t wr,
  input wire logic adapter_oc_pin,
  input wire logic dchg_oc_pin,
  input wire logic low_rail_pin,
  input wire logic adapter_present_pin,
  input wire logic lp_mode_pin,
  output logic [15:0] control_word_a,
  output logic [15:0] control_word_b,
  output logic [15:0] control_word_c,
  output ccc_pkg::ccc_cfg_t cfg,
  output logic charge_enable,
  output logic watchdog_expired,
  output logic alert_o,
  output logic alert_oe
);
  localparam logic [7:0] US_LAST = 8'(ccc_pkg::TICK_US_CYCLES - 1);
  localparam logic [9:0] MS_LAST = 10'(ccc_pkg::US_PER_MS - 1);
  localparam logic [ccc_pkg::WD_W-1:0] WD_LAST =
    ccc_pkg::WD_W'(TIMEOUT_MS - 1);

  ccc_pkg::ccc_state_t st;
  ccc_pkg::ccc_state_t next_st;
  logic [ccc_pkg::NIN-1:0] raw_in;
  logic us_tick;
  logic ms_tick;
  logic ceil_wr;
  logic wd_en;
  logic cmp_ref;
  logic [ccc_pkg::NSRC-1:0] src_raw;
  logic [ccc_pkg::NSRC-1:0] src_act;
  logic [ccc_pkg::NSRC-1:0][ccc_pkg::CNT_W-1:0] lim;

  assign raw_in = {lp_mode_pin, adapter_present_pin, low_rail_pin,
                   dchg_oc_pin, adapter_oc_pin};
  assign us_tick = (st.us_div == US_LAST);
  assign ms_tick = us_tick && (st.ms_div == MS_LAST);
  assign ceil_wr = wr.valid && (wr.cmd == ccc_pkg::CMD_CHG_CUR ||
                   wr.cmd == ccc_pkg::CMD_CHG_VOLT);
  assign wd_en = st.filt[ccc_pkg::IN_ADP] &&
                 !st.ctrl_a[ccc_pkg::A_WDOG_DIS]; // [RQ8]
  // comparator reference lives with adapter or power monitor
  assign cmp_ref = st.filt[ccc_pkg::IN_ADP] ||
                   st.ctrl_b[ccc_pkg::B_SYSTEM_POWER_MONITOR_EN]; // [RQ15] [RQ16]

  always_comb begin
    src_raw[0] = st.filt[ccc_pkg::IN_AC];
    src_raw[1] = st.filt[ccc_pkg::IN_DC] && cmp_ref; // [RQ11] [RQ15]
    src_raw[2] = st.filt[ccc_pkg::IN_LR];
    lim[0] = ccc_pkg::DBC_US_TABLE[st.ctrl_c[ccc_pkg::C_DBC_LSB +: 2]];
    lim[1] = lim[0]; // [RQ1]
    lim[2] = ccc_pkg::LOW_RAIL_DBC_US; // [RQ2]
    for (int i = 0; i < ccc_pkg::NSRC; i++) begin
      src_act[i] = (st.dbc_cnt[i] > lim[i]);
    end
  end

  always_comb begin
    next_st = st;
    next_st.s1 = raw_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < ccc_pkg::NIN; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
    next_st.us_div = us_tick ? 8'h00 : st.us_div + 8'h01;
    if (us_tick) begin
      next_st.ms_div = ms_tick ? 10'h000 : st.ms_div + 10'h001;
    end
    if (wr.valid) begin
      unique case (wr.cmd)
        ccc_pkg::CMD_CTRL_A: begin
          next_st.ctrl_a = {8'h00, wr.data[ccc_pkg::A_USED_W-1:0]}; // [RQ4]
        end
        ccc_pkg::CMD_CTRL_B: begin
          next_st.ctrl_b = wr.data; // [RQ5]
        end
        ccc_pkg::CMD_CTRL_C: begin
          next_st.ctrl_c = wr.data; // [RQ5]
        end
        default: begin
        end
      endcase
    end
    // watchdog: a live host keeps rewriting the charge ceilings
    if (ceil_wr) begin
      next_st.wd_cnt = '0; // [RQ17]
      next_st.timed_out = 1'b0; // [RQ7]
    end else if (wd_en && ms_tick && !st.timed_out) begin
      if (st.wd_cnt >= WD_LAST) begin
        next_st.timed_out = 1'b1; // [RQ6]
      end else begin
        next_st.wd_cnt = st.wd_cnt + ccc_pkg::WD_W'(1); // [RQ17]
      end
    end
    for (int i = 0; i < ccc_pkg::NSRC; i++) begin
      if (!src_raw[i]) begin
        next_st.dbc_cnt[i] = '0;
      end else if (us_tick && !src_act[i]) begin
        next_st.dbc_cnt[i] = st.dbc_cnt[i] + ccc_pkg::CNT_W'(1); // [RQ1] [RQ2]
      end
    end
    // hold reloads only on a fresh assertion
    if (!st.alert) begin
      if (|src_act) begin
        next_st.alert = 1'b1; // [RQ14]
        next_st.hold_cnt = ccc_pkg::HOLD_US_TABLE[
          st.ctrl_c[ccc_pkg::C_HOLD_LSB +: 3]] + ccc_pkg::CNT_W'(1); // [RQ3]
      end
    end else begin
      if (us_tick && st.hold_cnt != '0) begin
        next_st.hold_cnt = st.hold_cnt - ccc_pkg::CNT_W'(1); // [RQ3]
      end
      if (st.hold_cnt == '0 && !(|src_act)) begin
        next_st.alert = 1'b0; // [RQ14]
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.ctrl_a <= ccc_pkg::RST_CTRL_A;
      st.ctrl_b <= ccc_pkg::RST_CTRL_B;
      st.ctrl_c <= ccc_pkg::RST_CTRL_C;
    end else begin
      st <= next_st;
    end
  end

  assign control_word_a = st.ctrl_a;
  assign control_word_b = st.ctrl_b;
  assign control_word_c = st.ctrl_c;
  assign cfg.hs_short_sel = st.ctrl_a[ccc_pkg::A_HS_SHORT_LSB +: 2]; // [RQ9]
  assign cfg.dchg_lp_sel = st.ctrl_a[ccc_pkg::A_DCHG_LP_LSB +: 2]; // [RQ10]
  // low-power threshold applies on battery only, with reference up
  assign cfg.dchg_lp_active = st.filt[ccc_pkg::IN_LP] &&
    !st.filt[ccc_pkg::IN_ADP] && cmp_ref; // [RQ11]
  assign cfg.vin_loop_dis = st.ctrl_a[ccc_pkg::A_VIN_DIS]; // [RQ12]
  assign cfg.vin_ref_sel = st.ctrl_a[ccc_pkg::A_VIN_REF_LSB +: 2]; // [RQ13]
  assign cfg.system_power_monitor_en = st.ctrl_b[ccc_pkg::B_SYSTEM_POWER_MONITOR_EN]; // [RQ16]
  assign cfg.cmp_ref_active = cmp_ref;
  assign charge_enable = !st.timed_out; // [RQ6]
  assign watchdog_expired = st.timed_out;
  assign alert_o = 1'b0;
  assign alert_oe = st.alert; // [RQ14]

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_ctrl_a_write: assert property ( // [RQ4]
    wr.valid && wr.cmd == 8'h39
    |=> control_word_a == {8'h00, $past(wr.data[7:0])})
    else $error("control_word_a not loaded from low byte");

  a_ctrl_bc_write: assert property ( // [RQ5]
    wr.valid && (wr.cmd == 8'h3c || wr.cmd == 8'h3d)
    |=> ($past(wr.cmd) == ccc_pkg::CMD_CTRL_B ? control_word_b
         : control_word_c) == $past(wr.data))
    else $error("control word b or c not loaded");

  a_ctrl_b_hold: assert property ( // [RQ5]
    !(wr.valid && wr.cmd == 8'h3c) |=> $stable(control_word_b))
    else $error("control_word_b changed without write");

  a_wdog_resume: assert property ( // [RQ7]
    ceil_wr |=> charge_enable && st.wd_cnt == '0)
    else $error("ceiling write did not resume charging");

  a_wdog_halt: assert property ( // [RQ6]
    $rose(watchdog_expired) |-> $past(wd_en) && $past(ms_tick)
    && $past(st.wd_cnt) == WD_LAST && !charge_enable)
    else $error("timeout at wrong count or condition");

  a_wdog_pause: assert property ( // [RQ17]
    !wd_en && !ceil_wr |=> $stable(st.wd_cnt))
    else $error("watchdog advanced while paused");

  a_wdog_disable: assert property ( // [RQ8]
    control_word_a[7] && !ceil_wr && !watchdog_expired
    |=> !watchdog_expired)
    else $error("timeout while watchdog disabled");

  a_dbc_select: assert property ( // [RQ1]
    $rose(src_act[0])
    |-> $past(st.dbc_cnt[0]) ==
        ccc_pkg::DBC_US_TABLE[$past(control_word_c[10:9])])
    else $error("adapter debounce length wrong");

  a_low_rail_dbc: assert property ( // [RQ2]
    $rose(src_act[2]) |-> $past(st.dbc_cnt[2]) == 14'h000a)
    else $error("low rail debounce not ten microseconds");

  a_alert_hold: assert property ( // [RQ3]
    $fell(alert_oe) |-> $past(st.hold_cnt) == '0)
    else $error("alert released before minimum hold");

  a_alert_rise: assert property ( // [RQ14]
    $rose(alert_oe) |-> $past(|src_act)
    && st.hold_cnt > ccc_pkg::HOLD_US_TABLE[$past(control_word_c[8:6])])
    else $error("alert asserted without debounced source");

  a_dchg_gate: assert property ( // [RQ15]
    !cmp_ref |=> st.dbc_cnt[1] == '0 || !$past(cmp_ref) && cmp_ref)
    else $error("discharge alert counted without reference");

  a_cfg_fields: assert property ( // [RQ13]
    wr.valid && wr.cmd == 8'h39
    |=> cfg.vin_ref_sel == $past(wr.data[1:0])
        && cfg.vin_loop_dis == $past(wr.data[2])
        && cfg.hs_short_sel == $past(wr.data[6:5])
        && cfg.dchg_lp_sel == $past(wr.data[4:3]))
    else $error("control_word_a fields not decoded");

  a_system_power_monitor_enable: assert property ( // [RQ16]
    cfg.system_power_monitor_en |-> cfg.cmp_ref_active)
    else $error("power monitor on but reference idle");

  a_lp_select: assert property ( // [RQ11]
    cfg.dchg_lp_active |-> cfg.system_power_monitor_en && !st.filt[3])
    else $error("low-power threshold active without monitor");

  a_ctrl_a_upper: assert property ( // [RQ4]
    control_word_a[15:8] == 8'h00)
    else $error("control_word_a unused bits set");

  a_ctrl_a_hold: assert property ( // [RQ4]
    !(wr.valid && wr.cmd == ccc_pkg::CMD_CTRL_A)
    |=> $stable(control_word_a))
    else $error("control_word_a changed without write");

  a_ctrl_c_hold: assert property ( // [RQ5]
    !(wr.valid && wr.cmd == ccc_pkg::CMD_CTRL_C)
    |=> $stable(control_word_c))
    else $error("control_word_c changed without write");

  a_system_power_monitor_write: assert property ( // [RQ16]
    wr.valid && wr.cmd == ccc_pkg::CMD_CTRL_B
    |=> cfg.system_power_monitor_en == $past(wr.data[ccc_pkg::B_SYSTEM_POWER_MONITOR_EN]))
    else $error("power monitor enable not taken from write");

  a_ref_source: assert property ( // [RQ15]
    cfg.cmp_ref_active == (st.filt[ccc_pkg::IN_ADP] || control_word_b[3]))
    else $error("comparator reference source wrong");

  a_alert_min: assert property ( // [RQ3]
    alert_oe && st.hold_cnt != '0 |=> alert_oe)
    else $error("alert dropped with hold time left");

  a_low_rail_restart: assert property ( // [RQ2]
    $fell(st.filt[ccc_pkg::IN_LR]) |=> st.dbc_cnt[2] == '0)
    else $error("low rail debounce not restarted");

  a_dchg_count: assert property ( // [RQ11]
    cmp_ref && st.filt[ccc_pkg::IN_DC] && us_tick && !src_act[1]
    |=> st.dbc_cnt[1] == $past(st.dbc_cnt[1]) + ccc_pkg::CNT_W'(1))
    else $error("discharge debounce not counting with reference");
endmodule : ccc_charger_ctrl

// *** ccc_host_model.sv ***
// write-word host model for the charger control block
// assumes the block samples wr on the rising edge of clk_sys
`timescale 1ns/1ps
module ccc_host_model (
  input wire logic clk_sys,
  output ccc_pkg::ccc_wr_t wr
);
  initial wr = '0;
  // one whole word per pulse; idle fields show the inverse afterwards
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d);
    @(negedge clk_sys);
    wr <= '{valid: 1'b1, cmd: cmd, data: d};
    @(negedge clk_sys);
    wr <= '{valid: 1'b0, cmd: ~cmd, data: ~d};
  endtask : write_word
endmodule : ccc_host_model

// *** ccc_charger_ctrl_tb.sv ***
// self-checking bench of the charger control block
// assumes the host model launches writes off the falling edge
`timescale 1ns/1ps
module ccc_charger_ctrl_tb;
  logic clk_sys, arst_n, ac, dc, lr, adp, lp, chg, wdx, al, aoe;
  ccc_pkg::ccc_wr_t wr;
  ccc_pkg::ccc_cfg_t cfg, ecfg;
  logic [15:0] wa, wb, wc, ea, eb, ec, d;
  logic [7:0] cmd;
  int err_count, n_tests, cyc, seed;
  ccc_host_model host_u (.clk_sys(clk_sys), .wr(wr));
  ccc_charger_ctrl #(.TIMEOUT_MS(1)) dut_u (.clk_sys(clk_sys),
    .arst_n(arst_n), .wr(wr), .adapter_oc_pin(ac), .dchg_oc_pin(dc),
    .low_rail_pin(lr), .adapter_present_pin(adp), .lp_mode_pin(lp),
    .control_word_a(wa), .control_word_b(wb), .control_word_c(wc),
    .cfg(cfg), .charge_enable(chg), .watchdog_expired(wdx),
    .alert_o(al), .alert_oe(aoe));
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 100000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic rst();
    @(negedge clk_sys);
    {ac, dc, lr, adp, lp} = '0;
    arst_n = 0;
    ea = 0;
    eb = 0;
    ec = 0;
    repeat (4) @(negedge clk_sys);
    arst_n = 1;
  endtask : rst
  task automatic wr_model(logic [7:0] c, logic [15:0] v);
    host_u.write_word(c, v);
    if (c == 8'h39) ea = {8'h00, v[7:0]};
    if (c == 8'h3c) eb = v;
    if (c == 8'h3d) ec = v;
  endtask : wr_model
  task automatic chk_regs();
    ecfg = {ea[6:5], ea[4:3], lp & !adp & (adp | eb[3]), ea[2], ea[1:0],
            eb[3], adp | eb[3]};
    chk("control_word_a", ea, wa);
    chk("control_word_b", eb, wb);
    chk("control_word_c", ec, wc);
    chk("cfg", 16'(ecfg), 16'(cfg));
    chk("charge_enable", 1, chg);
    chk("watchdog_expired", 0, wdx);
    chk("alert_o", 0, al);
  endtask : chk_regs
  // low before lo us, at the expected level by hi us
  task automatic alert_win(int lo, int hi, logic e);
    repeat (lo * 250) @(negedge clk_sys);
    chk("alert_early", 0, aoe);
    repeat ((hi - lo) * 250) @(negedge clk_sys);
    chk("alert_late", 16'(e), aoe);
  endtask : alert_win
  initial begin
    seed = 98354;
    arst_n = 0;
    {ac, dc, lr, adp, lp} = '0;
    rst();
    chk_regs();
    chk("alert_oe", 0, aoe);
    $display("test reset_values done");
    for (int i = 0; i < 16; i++) begin
      cmd = (i % 4 == 0) ? 8'h39 : (i % 4 == 1) ? 8'h3c :
            (i % 4 == 2) ? 8'h3d : 8'h2a;
      d = 16'($random(seed));
      @(negedge clk_sys);
      adp = 1'($random(seed));
      lp = 1'($random(seed));
      wr_model(cmd, d);
      repeat (8) @(negedge clk_sys);
      chk_regs();
    end
    wr_model(8'h14, 16'h1234);
    wr_model(8'h15, 16'h4321);
    chk("charge_enable", 1, chg);
    $display("test register_writes done");
    rst();
    wr_model(8'h3d, 16'h0000);
    lr = 1;
    alert_win(10, 12, 1);
    lr = 0;
    repeat (5000) @(negedge clk_sys);
    chk("alert_hold", 1, aoe);
    $display("test low_rail done");
    rst();
    wr_model(8'h3d, 16'h0200);
    ac = 1;
    alert_win(100, 102, 1);
    $display("test adapter_oc done");
    rst();
    wr_model(8'h3d, 16'h0000);
    dc = 1;
    alert_win(10, 12, 0);
    wr_model(8'h3c, 16'h0008);
    alert_win(7, 9, 1);
    $display("test discharge_oc done");
    final_report();
  end
endmodule : ccc_charger_ctrl_tb
